// ===== verilog/irq_consts.svh
// Summary of operation
// R1 - Wake from sleep only by clock-free sources enabled before sleep was entered.
// R2 - After wake, vector if global enable set, else continue after sleep.
// R3 - Instruction after sleep always executes before any branch to the handler.
// R4 - External pin gives an edge interrupt, enabled by the external pin enable.
// R5 - Edge select set means rising edge, clear means falling edge.
// R6 - Valid edge sets external flag; redirect only with global and external enables.
// R7 - Interrupt entry pushes the return program counter onto the stack.
// R8 - Entry copies W, status minus expiry/power-down, bank, pointers, PC latch to shadows.
// R9 - Exit restores context from shadows; live edits lost, shadow edits kept.
// R10 - Shadow registers sit in data bank 31, readable and writable.
// R11 - Each flag sets on its event regardless of any enable.
// R12 - Software clears flags before setting their enables.
// R13 - Pin-change flag is read-only, clears when all pin-change flags clear.
// R14 - Taken interrupt loads the program counter with vector 0004h.
// R15 - Global enable clears on entry; later events only set flags.
// R16 - Return pops address, restores context, sets global enable again.
// R17 - Latency three to four cycles synchronous, three to five asynchronous.
// R18 - Request when global enable and an enabled core or peripheral source is flagged.
// R19 - Control register bits 7..0: glob_en, per_en, t0ie, inte, chg_en, t0if, ext_flag, chg_flag.
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH

// =========================================================
// Register offsets (byte addresses)
`define OFS_IRQ_CTRL     8'h00
`define OFS_PERIPH_EN    8'h04
`define OFS_EDGE_CFG     8'h08
`define OFS_PERIPH_FLAGS 8'h0C
`define OFS_CORE_STATE   8'h10
`define OFS_SHADOW_BASE  8'h40
`define SHADOW_BANK      31

// =========================================================
// Control register fields
`define BIT_GLOB_EN  7
`define BIT_PER_EN   6
`define BIT_T0IE     5
`define BIT_INTE     4
`define BIT_CHG_EN   3
`define BIT_T0IF     2
`define BIT_EXT_FLAG 1
`define BIT_CHG_FLAG 0

// =========================================================
// Shadow slots, status save mask, vector, reset values
`define SH_W       3'h0
`define SH_STATUS  3'h1
`define SH_BANK    3'h2
`define SH_PTR0L   3'h3
`define SH_PTR0H   3'h4
`define SH_PTR1L   3'h5
`define SH_PTR1H   3'h6
`define SH_LATCH   3'h7
`define STATUS_SAVE_MASK 8'hE7
`define IRQ_VECTOR       15'h0004
`define REG_RESET        8'h00
`endif

// ===== verilog/irq_pkg.sv
package irq_pkg;
	typedef enum logic [1:0] {ST_RUN, ST_SLEEP, ST_WAKE_ONE} seq_state_t;
	typedef enum logic [2:0] {SEL_CTRL, SEL_PEN, SEL_EDGE, SEL_PFLAG, SEL_STATE,
		SEL_SHADOW, SEL_NONE} reg_sel_t;

	typedef struct packed {
		logic [7:0][7:0] mem;
		logic [7:0]      rd;
	} shadow_state_t;

	typedef struct packed {
		seq_state_t  st;
		logic        glob_en;
		logic        per_en;
		logic        t0ie;
		logic        inte;
		logic        chg_en;
		logic        t0if;
		logic        ext_flag;
		logic        edge_sel;
		logic [7:0]  pie;
		logic        pin;
		logic        take;
		logic        restore;
		logic        wake;
		logic [14:0] ret_pc;
		logic        snap_int;
		logic        snap_ioc;
		logic [7:0]  snap_per;
	} ctrl_state_t;
endpackage

// ===== verilog/shadow_regs.sv
`timescale 1ns/1ps
`include "irq_consts.svh"
module shadow_regs
	import irq_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        nrst_i,
	input  wire logic        load_i,
	input  wire logic [63:0] load_data_i,
	input  wire logic        wr_i,
	input  wire logic [2:0]  wr_addr_i,
	input  wire logic [7:0]  wr_data_i,
	input  wire logic [2:0]  rd_addr_i,
	output logic      [7:0]  rd_data_o,
	output logic      [63:0] mem_o
);
	shadow_state_t q, d;

	// =========================================================
	// Entry save beats a software write in the same cycle
	always_comb
	begin
		d = q;
		if (load_i)
			d.mem = load_data_i; // [R8]
		else if (wr_i)
			d.mem[wr_addr_i] = wr_data_i; // [R9]
		d.rd = q.mem[rd_addr_i];
	end

	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			q <= '0;
		else
			q <= d;
	end

	assign rd_data_o = q.rd;
	assign mem_o     = q.mem;

	property p_shadow_write;
		@(posedge core_clk_i) disable iff (!nrst_i)
		(wr_i && !load_i) |=> (mem_o[$past(wr_addr_i)*8 +: 8] == $past(wr_data_i));
	endproperty
	a_shadow_write: assert property (p_shadow_write) // [R10]
		else $error("shadow write lost");
endmodule

// ===== verilog/irq_ctrl.sv
`timescale 1ns/1ps
`include "irq_consts.svh"
module irq_ctrl
	import irq_pkg::*;
#(
	parameter logic [7:0] WAKE_CAPABLE = 8'h00
)
(
	input  wire logic        core_clk_i,
	input  wire logic        nrst_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        ext_pin_i,
	input  wire logic        timer0_overflow_i,
	input  wire logic [5:0]  pin_change_flags_i,
	input  wire logic [7:0]  periph_flags_i,
	input  wire logic        instr_boundary_i,
	input  wire logic        sleep_i,
	input  wire logic        return_from_interrupt_i,
	input  wire logic [14:0] pc_i,
	input  wire logic [7:0]  ctx_w_i,
	input  wire logic [7:0]  ctx_status_i,
	input  wire logic [7:0]  ctx_bank_i,
	input  wire logic [15:0] ctx_ptr0_i,
	input  wire logic [15:0] ctx_ptr1_i,
	input  wire logic [7:0]  ctx_latch_i,
	output logic             irq_take_o,
	output logic [14:0]      vector_o,
	output logic             stack_push_o,
	output logic [14:0]      stack_data_o,
	output logic             restore_o,
	output logic [7:0]       rst_w_o,
	output logic [7:0]       rst_status_o,
	output logic [7:0]       rst_bank_o,
	output logic [15:0]      rst_ptr0_o,
	output logic [15:0]      rst_ptr1_o,
	output logic [7:0]       rst_latch_o,
	output logic             wake_o,
	output logic             sleeping_o
);
	ctrl_state_t q, d;
	logic [63:0] sh_mem;
	logic [63:0] sh_load_data;
	logic [7:0]  sh_rd;
	logic        setup_ph;
	logic        access_ph;
	logic        wr_acc;
	logic        sh_wr;
	logic        chg_flag;
	logic        ext_edge;
	logic        irq_req;
	logic        take_now;
	logic        wake_ev;
	logic [7:0]  ctrl_rd;
	reg_sel_t    sel;

	// =========================================================
	// Address decode, shared by read mux and write strobes
	function automatic reg_sel_t decode(input logic [7:0] a);
		if (a == `OFS_IRQ_CTRL)
			return SEL_CTRL;
		else if (a == `OFS_PERIPH_EN)
			return SEL_PEN;
		else if (a == `OFS_EDGE_CFG)
			return SEL_EDGE;
		else if (a == `OFS_PERIPH_FLAGS)
			return SEL_PFLAG;
		else if (a == `OFS_CORE_STATE)
			return SEL_STATE;
		else if ({a[7:5], 5'h00} == `OFS_SHADOW_BASE && a[1:0] == 2'b00)
			return SEL_SHADOW;
		else
			return SEL_NONE;
	endfunction

	// =========================================================
	// APB slave: zero wait states, error on unmapped words
	assign setup_ph  = psel_i && !penable_i;
	assign access_ph = psel_i && penable_i;
	assign wr_acc    = access_ph && pwrite_i;
	assign sel       = decode(paddr_i);
	assign sh_wr     = wr_acc && sel == SEL_SHADOW;
	assign pready_o  = access_ph;
	assign pslverr_o = access_ph && sel == SEL_NONE;

	// Pin-change summary follows the per-pin flags, software cannot write it
	assign chg_flag = |pin_change_flags_i; // [R13]

	assign ctrl_rd = {q.glob_en, q.per_en, q.t0ie, q.inte, q.chg_en, q.t0if, q.ext_flag,
		chg_flag}; // [R19]

	// Read data are flops except the live peripheral and pin-change flags; shadow data were fetched during the setup cycle
	always_comb
	begin
		prdata_o = 32'h0000_0000;
		if (access_ph && !pwrite_i)
		begin
			case (sel)
				SEL_CTRL:   prdata_o[7:0] = ctrl_rd;
				SEL_PEN:    prdata_o[7:0] = q.pie;
				SEL_EDGE:   prdata_o[0]   = q.edge_sel;
				SEL_PFLAG:  prdata_o[7:0] = periph_flags_i;
				SEL_STATE:  prdata_o[1:0] = q.st;
				SEL_SHADOW: prdata_o[7:0] = sh_rd; // [R10]
				default:    prdata_o = 32'h0000_0000;
			endcase
		end
	end

	// =========================================================
	// Request and wake detection
	assign ext_edge = q.edge_sel ? (ext_pin_i && !q.pin) : (!ext_pin_i && q.pin); // [R5]
	assign irq_req  = q.glob_en && ((q.t0ie && q.t0if) || (q.inte && q.ext_flag) ||
		(q.chg_en && chg_flag) || (q.per_en && |(q.pie & periph_flags_i))); // [R18] [R6]
	// Only checked in run state, so the post-wake instruction always finishes first
	// One cycle from request to take keeps entry well inside the allowed latency
	assign take_now = q.st == ST_RUN && irq_req && instr_boundary_i; // [R2] [R3] [R17]
	// Snapshot enables only: enabling during sleep cannot wake the core
	assign wake_ev  = (q.snap_int && q.ext_flag) || (q.snap_ioc && chg_flag) ||
		|(q.snap_per & periph_flags_i); // [R1]

	// Entry image: status keeps the shadow's own expiry and power-down bits
	assign sh_load_data = {ctx_latch_i, ctx_ptr1_i[15:8], ctx_ptr1_i[7:0],
		ctx_ptr0_i[15:8], ctx_ptr0_i[7:0], ctx_bank_i,
		(ctx_status_i & `STATUS_SAVE_MASK) | (sh_mem[15:8] & ~`STATUS_SAVE_MASK),
		ctx_w_i}; // [R8]

	// =========================================================
	// Next state
	always_comb
	begin
		d         = q;
		d.pin     = ext_pin_i;
		d.take    = 1'b0;
		d.restore = 1'b0;
		d.wake    = 1'b0;
		// Software writes first, so hardware events below win over a clear
		if (wr_acc && sel == SEL_CTRL)
		begin
			d.glob_en  = pwdata_i[`BIT_GLOB_EN];
			d.per_en   = pwdata_i[`BIT_PER_EN];
			d.t0ie     = pwdata_i[`BIT_T0IE];
			d.inte     = pwdata_i[`BIT_INTE]; // [R4]
			d.chg_en   = pwdata_i[`BIT_CHG_EN];
			d.t0if     = pwdata_i[`BIT_T0IF];
			d.ext_flag = pwdata_i[`BIT_EXT_FLAG];
		end
		if (wr_acc && sel == SEL_PEN)
			d.pie = pwdata_i[7:0];
		if (wr_acc && sel == SEL_EDGE)
			d.edge_sel = pwdata_i[0];
		// Flags set on their events whatever the enables say
		if (timer0_overflow_i)
			d.t0if = 1'b1; // [R11]
		if (ext_edge)
			d.ext_flag = 1'b1; // [R6] [R11]
		case (q.st)
			ST_RUN:
			begin
				if (take_now)
				begin
					d.take   = 1'b1; // [R14]
					d.glob_en = 1'b0; // [R15]
					d.ret_pc = pc_i; // [R7]
				end
				else if (return_from_interrupt_i)
				begin
					d.restore = 1'b1; // [R9] [R16]
					d.glob_en = 1'b1; // [R16]
				end
				else if (sleep_i)
				begin
					d.st       = ST_SLEEP;
					d.snap_int = q.inte; // [R1]
					d.snap_ioc = q.chg_en;
					d.snap_per = q.per_en ? (q.pie & WAKE_CAPABLE) : 8'h00;
				end
			end
			ST_SLEEP:
			begin
				if (wake_ev)
				begin
					d.st   = ST_WAKE_ONE;
					d.wake = 1'b1;
				end
			end
			ST_WAKE_ONE:
			begin
				if (instr_boundary_i)
					d.st = ST_RUN; // [R3]
			end
			default:
				d.st = ST_RUN;
		endcase
	end

	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			q <= '0;
		else
			q <= d;
	end

	// =========================================================
	// Shadow store in bank 31
	shadow_regs u_shadow (
		.core_clk_i  (core_clk_i),
		.nrst_i      (nrst_i),
		.load_i      (take_now),
		.load_data_i (sh_load_data),
		.wr_i        (sh_wr),
		.wr_addr_i   (paddr_i[4:2]),
		.wr_data_i   (pwdata_i[7:0]),
		.rd_addr_i   (paddr_i[4:2]),
		.rd_data_o   (sh_rd),
		.mem_o       (sh_mem)
	);

	// =========================================================
	// Sequencer outputs
	assign irq_take_o   = q.take;
	assign vector_o     = `IRQ_VECTOR; // [R14]
	assign stack_push_o = q.take; // [R7]
	assign stack_data_o = q.ret_pc;
	assign restore_o    = q.restore;
	assign rst_w_o      = sh_mem[7:0]; // [R9]
	assign rst_status_o = sh_mem[15:8];
	assign rst_bank_o   = sh_mem[23:16];
	assign rst_ptr0_o   = sh_mem[39:24];
	assign rst_ptr1_o   = sh_mem[55:40];
	assign rst_latch_o  = sh_mem[63:56];
	assign wake_o       = q.wake;
	assign sleeping_o   = q.st == ST_SLEEP;

	// =========================================================
	// Checks
	sequence s_entry;
		q.st == ST_RUN && irq_req && instr_boundary_i;
	endsequence

	property p_take_cause;
		@(posedge core_clk_i) disable iff (!nrst_i)
		irq_take_o |-> $past(irq_req) && $past(instr_boundary_i);
	endproperty
	a_take_cause: assert property (p_take_cause) // [R18]
		else $error("take without request");

	property p_entry_push;
		@(posedge core_clk_i) disable iff (!nrst_i)
		s_entry |=> stack_push_o && stack_data_o == $past(pc_i) && !q.glob_en;
	endproperty
	a_entry_push: assert property (p_entry_push) // [R7]
		else $error("entry push wrong");

	property p_glob_off;
		@(posedge core_clk_i) disable iff (!nrst_i)
		irq_take_o |-> !q.glob_en && vector_o == 15'h0004;
	endproperty
	a_glob_off: assert property (p_glob_off) // [R15]
		else $error("global enable not cleared");

	property p_shadow_w;
		@(posedge core_clk_i) disable iff (!nrst_i)
		s_entry |=> rst_w_o == $past(ctx_w_i) && rst_bank_o == $past(ctx_bank_i);
	endproperty
	a_shadow_w: assert property (p_shadow_w) // [R8]
		else $error("context not saved");

	property p_return;
		@(posedge core_clk_i) disable iff (!nrst_i)
		(q.st == ST_RUN && !take_now && return_from_interrupt_i) |=> restore_o && q.glob_en;
	endproperty
	a_return: assert property (p_return) // [R16]
		else $error("return did not restore");

	property p_rise_edge;
		@(posedge core_clk_i) disable iff (!nrst_i)
		(q.edge_sel && !q.pin && ext_pin_i) |=> q.ext_flag;
	endproperty
	a_rise_edge: assert property (p_rise_edge) // [R5]
		else $error("rising edge missed");

	property p_flag_indep;
		@(posedge core_clk_i) disable iff (!nrst_i)
		timer0_overflow_i |=> q.t0if;
	endproperty
	a_flag_indep: assert property (p_flag_indep) // [R11]
		else $error("timer flag not set");

	property p_wake_one;
		@(posedge core_clk_i) disable iff (!nrst_i)
		wake_o |-> !irq_take_o ##1 !irq_take_o;
	endproperty
	a_wake_one: assert property (p_wake_one) // [R3]
		else $error("vectored before post-sleep instruction");

	property p_no_wake;
		@(posedge core_clk_i) disable iff (!nrst_i)
		(sleeping_o && !q.snap_int && !q.snap_ioc && q.snap_per == 8'h00) |=> sleeping_o;
	endproperty
	a_no_wake: assert property (p_no_wake) // [R1]
		else $error("woke without enabled source");

	property p_ioc_ro;
		@(posedge core_clk_i) disable iff (!nrst_i)
		(access_ph && !pwrite_i && sel == SEL_CTRL) |-> prdata_o[0] == |pin_change_flags_i;
	endproperty
	a_ioc_ro: assert property (p_ioc_ro) // [R13]
		else $error("pin-change summary wrong");
endmodule

// ===== bench/cpu_seq_model.sv
`timescale 1ns/1ps
// =========================================
// Instruction sequencer stand-in
module cpu_seq_model
	import irq_pkg::*;
(
	input  wire logic        core_clk_i,
	input  wire logic        nrst_i,
	input  wire logic        run_i,
	input  wire logic        take_i,
	input  wire logic [14:0] vector_i,
	output logic             boundary_o,
	output logic [14:0]      pc_o,
	output logic [7:0]       w_o,
	output logic [7:0]       status_o,
	output logic [15:0]      ptr0_o,
	output logic [15:0]      ptr1_o,
	output logic [7:0]       bank_o,
	output logic [7:0]       latch_o,
	output logic [7:0]       take_cnt_o
);
	// Holding run low models a slow core that finishes no instruction
	assign boundary_o = run_i;
	// Fixed live context, status has expiry and power-down set on purpose
	assign w_o      = 8'h5a;
	assign status_o = 8'hff;
	assign bank_o   = 8'h1f;
	assign ptr0_o   = 16'h1234;
	assign ptr1_o   = 16'h5678;
	assign latch_o  = 8'h03;
	// Program counter jumps to the vector and entries are counted
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			pc_o       <= 15'h0123;
			take_cnt_o <= 8'h00;
		end
		else if (take_i)
		begin
			pc_o       <= vector_i;
			take_cnt_o <= take_cnt_o + 8'h01;
		end
	end
endmodule

// ===== bench/test_cpu_interrupt_control_unit.sv
`timescale 1ns/1ps
module test_cpu_interrupt_control_unit
	import irq_pkg::*;
;
	logic        core_clk, nrst, psel, penable, pwrite, pready, pslverr;
	logic        ext_pin, t0_ovf, boundary, sleep_req, ret_req, run;
	logic        take, push, restore, wake, sleeping, rerr;
	logic [7:0]  paddr, per_flags, w, st, bank, pcl, r_w, r_st, r_bank, r_pcl, takes;
	logic [31:0] pwdata, prdata, rdata;
	logic [5:0]  pc_flags;
	logic [14:0] pc, vector, stack_data;
	logic [15:0] f0, f1, r_f0, r_f1;
	int          n_fail, checks;

	irq_ctrl dut (.core_clk_i(core_clk), .nrst_i(nrst), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .ext_pin_i(ext_pin),
		.timer0_overflow_i(t0_ovf), .pin_change_flags_i(pc_flags),
		.periph_flags_i(per_flags), .instr_boundary_i(boundary), .sleep_i(sleep_req),
		.return_from_interrupt_i(ret_req), .pc_i(pc), .ctx_w_i(w), .ctx_status_i(st),
		.ctx_bank_i(bank), .ctx_ptr0_i(f0), .ctx_ptr1_i(f1), .ctx_latch_i(pcl),
		.irq_take_o(take), .vector_o(vector), .stack_push_o(push),
		.stack_data_o(stack_data), .restore_o(restore), .rst_w_o(r_w),
		.rst_status_o(r_st), .rst_bank_o(r_bank), .rst_ptr0_o(r_f0), .rst_ptr1_o(r_f1),
		.rst_latch_o(r_pcl), .wake_o(wake), .sleeping_o(sleeping));

	cpu_seq_model cpu (.core_clk_i(core_clk), .nrst_i(nrst), .run_i(run), .take_i(take),
		.vector_i(vector), .boundary_o(boundary), .pc_o(pc), .w_o(w), .status_o(st),
		.ptr0_o(f0), .ptr1_o(f1), .bank_o(bank), .latch_o(pcl), .take_cnt_o(takes));

	// =========================================
	// Reporting
	task stop_test;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("BAD %s exp %h seen %h", n, exp, seen);
		end
	endtask

	// =========================================
	// APB master, request held until pready is seen high
	task apb(input logic wr, input logic [7:0] a, input logic [7:0] d);
		int i;
		@(posedge core_clk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge core_clk);
		penable <= 1'b1;
		for (i = 0; i < 8; i++)
		begin
			@(posedge core_clk);
			if (pready === 1'b1)
				break;
		end
		if (i == 8)
		begin
			n_fail++;
			stop_test;
		end
		rdata = prdata;
		rerr  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	// Bounded wait for entry (sel high) or wake (sel low)
	task wait_out(input logic sel);
		int i;
		for (i = 0; i < 8; i++)
		begin
			@(posedge core_clk);
			#1;
			if ((sel ? take : wake) === 1'b1)
				break;
		end
		if (i == 8)
		begin
			n_fail++;
			stop_test;
		end
	endtask

	// =========================================
	// Scenarios
	task test_regs;
		apb(0, 8'h00, 8'h00);
		chk("ctrl reset", rdata, 32'h0000_0000);
		apb(0, 8'h04, 8'h00);
		chk("periph enable reset", rdata, 32'h0000_0000);
		apb(0, 8'h3c, 8'h00);
		chk("unmapped error", {31'h0, rerr}, 32'h0000_0001);
		chk("unmapped data", rdata, 32'h0000_0000);
		$display("test regs done");
	endtask

	// Flags set with every enable off; edge select picks the edge
	task test_flags;
		@(posedge core_clk);
		t0_ovf  <= 1'b1;
		@(posedge core_clk);
		t0_ovf  <= 1'b0;
		ext_pin <= 1'b1;
		repeat (3) @(posedge core_clk);
		apb(0, 8'h00, 8'h00);
		chk("timer0 flag, rise ignored", rdata, 32'h0000_0004);
		@(posedge core_clk);
		ext_pin <= 1'b0;
		repeat (3) @(posedge core_clk);
		apb(0, 8'h00, 8'h00);
		chk("falling edge flag", rdata, 32'h0000_0006);
		apb(1, 8'h00, 8'h00);
		apb(1, 8'h08, 8'h01);
		apb(0, 8'h08, 8'h00);
		chk("edge select", rdata, 32'h0000_0001);
		@(posedge core_clk);
		ext_pin <= 1'b1;
		repeat (3) @(posedge core_clk);
		apb(0, 8'h00, 8'h00);
		chk("rising edge flag", rdata, 32'h0000_0002);
		apb(1, 8'h00, 8'h00);
		$display("test flags done");
	endtask

	// Summary pin-change flag ignores writes, follows the pin flags
	task test_pin_change;
		@(posedge core_clk);
		pc_flags <= 6'h05;
		repeat (2) @(posedge core_clk);
		apb(1, 8'h00, 8'h00);
		apb(0, 8'h00, 8'h00);
		chk("pin change kept", rdata, 32'h0000_0001);
		@(posedge core_clk);
		pc_flags <= 6'h04;
		repeat (2) @(posedge core_clk);
		apb(0, 8'h00, 8'h00);
		chk("pin change one left", rdata, 32'h0000_0001);
		@(posedge core_clk);
		pc_flags <= 6'h00;
		repeat (2) @(posedge core_clk);
		apb(0, 8'h00, 8'h00);
		chk("pin change cleared", rdata, 32'h0000_0000);
		$display("test pin change done");
	endtask

	// Entry from timer0, then handler edits a shadow and returns
	task test_take_return;
		apb(1, 8'h00, 8'ha0);
		@(posedge core_clk);
		run    <= 1'b1;
		t0_ovf <= 1'b1;
		@(posedge core_clk);
		t0_ovf <= 1'b0;
		wait_out(1'b1);
		chk("vector", {17'h0, vector}, 32'h0000_0004);
		chk("push", {31'h0, push}, 32'h0000_0001);
		chk("stack data", {17'h0, stack_data}, 32'h0000_0123);
		chk("shadow w", {24'h0, r_w}, 32'h0000_005a);
		chk("shadow status", {24'h0, r_st}, 32'h0000_00e7);
		chk("shadow ptrs", {r_f1, r_f0}, 32'h5678_1234);
		chk("shadow bank latch", {16'h0, r_bank, r_pcl}, 32'h0000_1f03);
		apb(0, 8'h00, 8'h00);
		chk("global cleared", rdata, 32'h0000_0024);
		apb(1, 8'h00, 8'h20);
		apb(1, 8'h40, 8'hc3);
		apb(0, 8'h40, 8'h00);
		chk("shadow rw", rdata, 32'h0000_00c3);
		@(posedge core_clk);
		ret_req <= 1'b1;
		@(posedge core_clk);
		ret_req <= 1'b0;
		#1;
		chk("restore", {31'h0, restore}, 32'h0000_0001);
		chk("restored w", {24'h0, r_w}, 32'h0000_00c3);
		apb(0, 8'h00, 8'h00);
		chk("global set", rdata, 32'h0000_00a0);
		$display("test take return done");
	endtask

	// Peripheral source needs its own and the peripheral enable
	task test_periph;
		apb(1, 8'h00, 8'h80);
		apb(1, 8'h04, 8'h01);
		@(posedge core_clk);
		per_flags <= 8'h01;
		repeat (4) @(posedge core_clk);
		chk("no entry without peripheral enable", {24'h0, takes}, 32'h0000_0001);
		apb(0, 8'h0c, 8'h00);
		chk("periph flags", rdata, 32'h0000_0001);
		apb(1, 8'h00, 8'hc0);
		wait_out(1'b1);
		@(posedge core_clk);
		per_flags <= 8'h00;
		apb(1, 8'h00, 8'h00);
		$display("test periph done");
	endtask

	// Wake by the pin, instruction after sleep runs before entry
	task test_sleep;
		apb(1, 8'h00, 8'h90);
		@(posedge core_clk);
		run     <= 1'b0;
		ext_pin <= 1'b0;
		@(posedge core_clk);
		sleep_req <= 1'b1;
		@(posedge core_clk);
		sleep_req <= 1'b0;
		#1;
		chk("sleeping", {31'h0, sleeping}, 32'h0000_0001);
		apb(0, 8'h10, 8'h00);
		chk("state sleep", rdata, 32'h0000_0001);
		@(posedge core_clk);
		ext_pin <= 1'b1;
		wait_out(1'b0);
		repeat (4) @(posedge core_clk);
		chk("no entry before boundary", {24'h0, takes}, 32'h0000_0002);
		run <= 1'b1;
		wait_out(1'b1);
		// Second sleep with the global enable off: wake, then carry on without a vector
		apb(1, 8'h00, 8'h10);
		@(posedge core_clk);
		run       <= 1'b0;
		ext_pin   <= 1'b0;
		sleep_req <= 1'b1;
		@(posedge core_clk);
		sleep_req <= 1'b0;
		ext_pin   <= 1'b1;
		wait_out(1'b0);
		@(posedge core_clk);
		run <= 1'b1;
		repeat (4) @(posedge core_clk);
		chk("no vector without global enable", {24'h0, takes}, 32'h0000_0003);
		apb(0, 8'h10, 8'h00);
		chk("running after wake", rdata, 32'h0000_0000);
		$display("test sleep done");
	endtask

	// =========================================
	// Clock, reset and sequence
	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	initial
	begin
		{nrst, psel, penable, pwrite, ext_pin, t0_ovf, sleep_req, ret_req, run} = 9'h000;
		paddr     = 8'h00;
		pwdata    = 32'h0000_0000;
		pc_flags  = 6'h00;
		per_flags = 8'h00;
		n_fail    = 0;
		checks    = 0;
		repeat (10) @(posedge core_clk);
		nrst <= 1'b1;
		test_regs;
		test_flags;
		test_pin_change;
		test_take_return;
		test_periph;
		test_sleep;
		stop_test;
	end
endmodule
